// ### hw/rbs_pkg.sv
// shared constants and types for the read block segmenter
package rbs_pkg;
  localparam int RX_DEPTH = 4096;
  localparam int OUT_DEPTH = 16;
  localparam int NPORT = 2;
  localparam logic [12:0] BLK_MAX = 13'h0190;
  localparam logic [12:0] CNT_RESET = 13'h0000;
  localparam logic [8:0] W_SEQ = 9'h000;
  localparam logic [8:0] P0_LEN = 9'h001;
  localparam logic [8:0] P0_TX = 9'h002;
  localparam logic [8:0] P0_DATA = 9'h003;
  localparam logic [8:0] P0_DATA_LAST = 9'h0ca;
  localparam logic [8:0] P1_LEN = 9'h0cb;
  localparam logic [8:0] P1_TX = 9'h0cc;
  localparam logic [8:0] P1_DATA = 9'h0cd;
  localparam logic [8:0] W_LAST = 9'h194;
  localparam logic [8:0] LOC_LEN = 9'h000;
  localparam logic [8:0] LOC_TX = 9'h001;
  localparam logic [8:0] LOC_ST_BUF = 9'h002;
  localparam logic [8:0] LOC_ST_MSG = 9'h003;
  localparam logic [8:0] LOC_ST_ERR = 9'h004;
  localparam logic [15:0] LEN_CONT = 16'hffff;
  localparam logic [6:0] SEQ_RESET = 7'h00;
  localparam logic [6:0] SEQ_MAX = 7'h7f;

  typedef logic [12:0] rbs_cnt_type;
  typedef logic [9:0] rbs_tx_type;

  typedef struct packed {
    logic valid;
    logic term;
    logic [7:0] data;
  } rbs_rx_type;

  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] data;
  } rbs_wr_type;

  typedef enum {ST_IDLE, ST_EMIT, ST_SEQ} rbs_state_type;
endpackage : rbs_pkg

// ### hw/rbs_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module rbs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  input wire logic out_ready,
  output logic out_valid,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  // depth must be a power of two: pointers wrap by overflow
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic ready_r, ready_nxt, valid_r, valid_nxt;
  logic push, pop;

  assign in_ready = ready_r;
  assign out_valid = valid_r;
  assign out_data = mem_r[rp_r];
  assign push = in_valid & ready_r;
  assign pop = valid_r & out_ready;

  always_comb begin
    wp_nxt = wp_r + AW'(push);
    rp_nxt = rp_r + AW'(pop);
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    ready_nxt = (cnt_nxt != CW'(D));
    valid_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
    end
  end

  // storage has no reset: contents behind the pointers are never read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : rbs_fifo

// ### hw/rbs_segmenter.sv
// read file builder: buffers port bytes and writes 400-byte blocks to host memory
//
// Behaviour
// R1 - word 0 carries sequence 0..127, bumped each block
// R2 - sequence wraps from 127 back to 0
// R3 - host treats sequence change as new block
// R4 - port 1 length word 1, data words 3..202
// R5 - port 2 length word 203, data 205..404
// R6 - word 2 reports port 1 accepted count
// R7 - word 204 reports port 2 accepted count
// R8 - each port buffers 4096 received bytes
// R9 - hold bytes until termination seen, then send
// R10 - over 400 left: length -1, full area
// R11 - final block length equals valid byte count
// R12 - host ends packet on positive length
// R13 - host resends write data when count zero
// R14 - accepted count equals bytes moved to transmitter
// R15 - own files while word0 equal, then differ
// R16 - no data: length zero, area holds status
`timescale 1ns/1ps
module rbs_segmenter (
  input wire logic sys_clk,
  input wire logic srst,
  input rbs_pkg::rbs_rx_type [1:0] rx_in,
  output logic [1:0] rx_ready,
  input rbs_pkg::rbs_tx_type [1:0] tx_acc,
  input wire logic [15:0] host_word0,
  input wire logic mem_ready,
  output logic mem_wr_en,
  output rbs_pkg::rbs_wr_type mem_wr
);
  import rbs_pkg::*;

  rbs_state_type state_r, state_nxt;
  logic [6:0] seq_r, seq_nxt, seq_inc;
  logic [8:0] w_r, w_nxt, loc_s;
  logic half_r, half_nxt, port_s, has_byte, is_data;
  rbs_cnt_type b_r, b_nxt;
  logic [7:0] lo_r, lo_nxt;
  rbs_cnt_type blk_r [NPORT];
  rbs_cnt_type blk_nxt [NPORT];
  logic [15:0] lenw_r [NPORT];
  logic [15:0] lenw_nxt [NPORT];
  rbs_tx_type txc_r [NPORT];
  rbs_tx_type txc_nxt [NPORT];
  rbs_cnt_type take [NPORT];
  rbs_cnt_type acc_r [NPORT];
  rbs_cnt_type acc_nxt [NPORT];
  rbs_cnt_type msg_r [NPORT];
  rbs_cnt_type msg_nxt [NPORT];
  logic [1:0] tpend_r, tpend_nxt, ovf_r, ovf_nxt, ovf_clr;
  logic [1:0] pop;
  logic [7:0] rx_byte [NPORT];
  logic opush, of_ready, of_valid;
  rbs_wr_type owr, of_data;
  logic en_r, en_nxt;
  rbs_wr_type wr_r, wr_nxt;

  assign mem_wr_en = en_r;
  assign mem_wr = wr_r;
  assign seq_inc = seq_r + 7'h01;
  assign port_s = (w_r >= P1_LEN);
  assign loc_s = port_s ? (w_r - P1_LEN) : (w_r - P0_LEN);
  assign is_data = (loc_s > LOC_TX);
  assign has_byte = (b_r < blk_r[port_s]);

  // per port receive buffer and message bookkeeping
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    rbs_cnt_type after;
    logic commit;

    // deep buffer lets a long message pile up before the host is needed
    rbs_fifo #(.W(8), .D(RX_DEPTH)) u_rx ( // [R8]
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(rx_in[i].valid),
      .in_data(rx_in[i].data),
      .in_ready(rx_ready[i]),
      .out_ready(pop[i]),
      .out_valid(),
      .out_data(rx_byte[i])
    );

    always_comb begin
      after = msg_r[i] - take[i];
      // only a terminated message becomes visible to the block builder
      commit = (rx_in[i].term | tpend_r[i]) && (after == CNT_RESET); // [R9]
      msg_nxt[i] = commit ? acc_r[i] : after;
      acc_nxt[i] = (commit ? CNT_RESET : acc_r[i])
                   + rbs_cnt_type'(rx_in[i].valid & rx_ready[i]);
      tpend_nxt[i] = (tpend_r[i] | rx_in[i].term) & ~commit;
      // overflow set beats the clear done by reporting status
      ovf_nxt[i] = (ovf_r[i] & ~ovf_clr[i]) | (rx_in[i].valid & ~rx_ready[i]);
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        acc_r[i] <= CNT_RESET;
        msg_r[i] <= CNT_RESET;
        tpend_r[i] <= 1'b0;
        ovf_r[i] <= 1'b0;
      end else begin
        acc_r[i] <= acc_nxt[i];
        msg_r[i] <= msg_nxt[i];
        tpend_r[i] <= tpend_nxt[i];
        ovf_r[i] <= ovf_nxt[i];
      end
    end
  end

  // block builder
  always_comb begin
    state_nxt = state_r;
    seq_nxt = seq_r;
    w_nxt = w_r;
    half_nxt = half_r;
    b_nxt = b_r;
    lo_nxt = lo_r;
    blk_nxt = blk_r;
    lenw_nxt = lenw_r;
    txc_nxt = txc_r;
    take = '{default: CNT_RESET};
    pop = 2'b00;
    ovf_clr = 2'b00;
    opush = 1'b0;
    owr = '0;
    case (state_r)
      ST_IDLE: begin
        // equal first words: the files are ours again
        if (host_word0 == {9'h000, seq_r}) begin // [R15]
          for (int i = 0; i < NPORT; i++) begin
            if (msg_r[i] > BLK_MAX) begin
              blk_nxt[i] = BLK_MAX; // [R10]
              lenw_nxt[i] = LEN_CONT; // [R10]
            end else begin
              blk_nxt[i] = msg_r[i]; // [R11] [R16]
              lenw_nxt[i] = {3'h0, msg_r[i]}; // [R11] [R16]
            end
            take[i] = blk_nxt[i];
            txc_nxt[i] = tx_acc[i]; // [R14]
          end
          w_nxt = P0_LEN;
          half_nxt = 1'b0;
          b_nxt = CNT_RESET;
          state_nxt = ST_EMIT;
        end
      end
      ST_EMIT: begin
        owr.addr = w_r; // [R4] [R5]
        if (loc_s == LOC_LEN) begin
          owr.data = lenw_r[port_s];
        end else if (loc_s == LOC_TX) begin
          owr.data = {6'h00, txc_r[port_s]}; // [R6] [R7]
        end else if (blk_r[port_s] == CNT_RESET) begin
          if (loc_s == LOC_ST_BUF) begin
            owr.data = {3'h0, acc_r[port_s] + msg_r[port_s]}; // [R16]
          end else if (loc_s == LOC_ST_MSG) begin
            owr.data = {3'h0, msg_r[port_s]}; // [R16]
          end else if (loc_s == LOC_ST_ERR) begin
            owr.data = {15'h0000, ovf_r[port_s]}; // [R16]
          end else begin
            owr.data = 16'h0000;
          end
        end else begin
          // low byte first; bytes past the block length read zero
          owr.data = {(has_byte ? rx_byte[port_s] : 8'h00), lo_r};
        end
        if (is_data && (blk_r[port_s] != CNT_RESET) && !half_r) begin
          pop[port_s] = has_byte;
          lo_nxt = has_byte ? rx_byte[port_s] : 8'h00;
          b_nxt = b_r + rbs_cnt_type'(has_byte);
          half_nxt = 1'b1;
        end else if (of_ready) begin
          opush = 1'b1;
          half_nxt = 1'b0;
          if (is_data && (blk_r[port_s] != CNT_RESET)) begin
            pop[port_s] = has_byte;
            b_nxt = b_r + rbs_cnt_type'(has_byte);
          end
          if (loc_s == LOC_LEN) begin
            b_nxt = CNT_RESET;
          end
          if ((loc_s == LOC_ST_ERR) && (blk_r[port_s] == CNT_RESET)) begin
            ovf_clr[port_s] = 1'b1;
          end
          w_nxt = w_r + 9'h001;
          if (w_r == W_LAST) begin
            state_nxt = ST_SEQ;
          end
        end
      end
      ST_SEQ: begin
        // sequence goes last so the host never sees a half-built block
        owr.addr = W_SEQ;
        owr.data = {9'h000, seq_inc}; // [R1]
        if (of_ready) begin
          opush = 1'b1;
          seq_nxt = seq_inc; // [R2]
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      seq_r <= SEQ_RESET;
      w_r <= P0_LEN;
      half_r <= 1'b0;
      b_r <= CNT_RESET;
      lo_r <= 8'h00;
      blk_r <= '{default: CNT_RESET};
      lenw_r <= '{default: 16'h0000};
      txc_r <= '{default: 10'h000};
    end else begin
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      w_r <= w_nxt;
      half_r <= half_nxt;
      b_r <= b_nxt;
      lo_r <= lo_nxt;
      blk_r <= blk_nxt;
      lenw_r <= lenw_nxt;
      txc_r <= txc_nxt;
    end
  end

  // word fifo toward host memory; a stalled host holds the builder
  rbs_fifo #(.W($bits(rbs_wr_type)), .D(OUT_DEPTH)) u_out (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(opush),
    .in_data(owr),
    .in_ready(of_ready),
    .out_ready(~en_r | mem_ready),
    .out_valid(of_valid),
    .out_data(of_data)
  );

  always_comb begin
    en_nxt = en_r;
    wr_nxt = wr_r;
    if (!en_r || mem_ready) begin
      en_nxt = of_valid;
      wr_nxt = of_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_r <= 1'b0;
      wr_r <= '0;
    end else begin
      en_r <= en_nxt;
      wr_r <= wr_nxt;
    end
  end

  chk_seq_step: assert property (@(posedge sys_clk) disable iff (srst) // [R1]
    (seq_r != $past(seq_r)) |-> (seq_r == 7'($past(seq_r) + 7'h01)))
    else $error("sequence did not advance by one");

  chk_seq_wrap: assert property (@(posedge sys_clk) disable iff (srst) // [R2]
    (state_r == ST_SEQ && of_ready && seq_r == SEQ_MAX) |=> (seq_r == SEQ_RESET))
    else $error("sequence did not wrap to zero");

  chk_own_wait: assert property (@(posedge sys_clk) disable iff (srst) // [R15]
    (state_r == ST_IDLE && host_word0 != {9'h000, seq_r}) |=> (state_r == ST_IDLE))
    else $error("block built while host owns files");

  chk_len_cont: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
    (state_r == ST_IDLE && state_nxt == ST_EMIT && msg_r[0] > BLK_MAX)
    |=> (lenw_r[0] == LEN_CONT && blk_r[0] == BLK_MAX))
    else $error("continuation block not marked");

  chk_len_final: assert property (@(posedge sys_clk) disable iff (srst) // [R11]
    (state_r == ST_IDLE && state_nxt == ST_EMIT && msg_r[1] <= BLK_MAX)
    |=> (lenw_r[1] == {3'h0, $past(msg_r[1])} && blk_r[1] == $past(msg_r[1])))
    else $error("final length differs from byte count");

  chk_tx_port1: assert property (@(posedge sys_clk) disable iff (srst) // [R6]
    (opush && owr.addr == P0_TX) |-> (owr.data == {6'h00, txc_r[0]}))
    else $error("port 1 accepted count misplaced");

  chk_tx_port2: assert property (@(posedge sys_clk) disable iff (srst) // [R7]
    (opush && owr.addr == P1_TX) |-> (owr.data == {6'h00, txc_r[1]}))
    else $error("port 2 accepted count misplaced");

  chk_addr_range: assert property (@(posedge sys_clk) disable iff (srst) // [R4] [R5]
    opush |-> (owr.addr <= W_LAST))
    else $error("write outside the read file");

  chk_hold_bytes: assert property (@(posedge sys_clk) disable iff (srst) // [R9]
    (pop != 2'b00) |-> (state_r == ST_EMIT && b_r < blk_r[port_s]))
    else $error("bytes taken without a terminated message");

  chk_status_zero: assert property (@(posedge sys_clk) disable iff (srst) // [R16]
    (opush && owr.addr == P0_LEN && blk_r[0] == CNT_RESET) |-> (owr.data == 16'h0000))
    else $error("status block length not zero");

  cov_cont_block: cover property (@(posedge sys_clk) disable iff (srst)
    opush && owr.addr == P0_LEN && owr.data == LEN_CONT);
  cov_seq_wrap: cover property (@(posedge sys_clk) disable iff (srst)
    state_r == ST_SEQ && of_ready && seq_r == SEQ_MAX);
  cov_both_data: cover property (@(posedge sys_clk) disable iff (srst)
    state_r == ST_EMIT && blk_r[0] != CNT_RESET && blk_r[1] != CNT_RESET);
  cov_host_stall: cover property (@(posedge sys_clk) disable iff (srst)
    state_r == ST_EMIT && !of_ready);
endmodule : rbs_segmenter

// ### verification/rbs_host_model.sv
// host memory model: stores read-file words and counts finished blocks
`timescale 1ns/1ps
module rbs_host_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic mem_wr_en,
  input rbs_pkg::rbs_wr_type mem_wr,
  output logic mem_ready
);
  import rbs_pkg::*;
  logic [15:0] mem [0:511];
  int blk_cnt = 0;
  logic ph = 1'b0;
  // words never written keep this marker
  initial for (int i = 0; i < 512; i++) mem[i] = 16'h5a5a;
  // slow host stalls every other cycle
  assign mem_ready = ~slow | ph;
  always @(posedge sys_clk) begin
    ph <= ~ph;
    if (!srst && mem_wr_en && mem_ready) begin
      mem[mem_wr.addr] <= mem_wr.data;
      if (mem_wr.addr == W_SEQ) begin
        blk_cnt <= blk_cnt + 1;
      end
    end
  end
endmodule : rbs_host_model

// ### verification/tb_rbs_segmenter.sv
// self-checking bench for the read block segmenter
`timescale 1ns/1ps
module tb_rbs_segmenter;
  import rbs_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  rbs_rx_type [1:0] rx_in = '0;
  logic [1:0] rx_ready;
  rbs_tx_type [1:0] tx_acc = '0;
  logic [15:0] host_word0 = 16'hffff;
  logic mem_ready;
  logic mem_wr_en;
  logic slow = 1'b0;
  rbs_wr_type mem_wr;
  int error_cnt = 0;
  int compares = 0;
  logic [6:0] seq = 7'h00;

  rbs_segmenter dut (.sys_clk(sys_clk), .srst(srst), .rx_in(rx_in), .rx_ready(rx_ready),
    .tx_acc(tx_acc), .host_word0(host_word0), .mem_ready(mem_ready),
    .mem_wr_en(mem_wr_en), .mem_wr(mem_wr));
  rbs_host_model host (.sys_clk(sys_clk), .srst(srst), .slow(slow), .mem_wr_en(mem_wr_en),
    .mem_wr(mem_wr), .mem_ready(mem_ready));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // leaves valid up so back-to-back bytes need no gap
  task send_byte(input int p, input logic [7:0] d);
    logic ok;
    int n;
    rx_in[p].valid = 1'b1;
    rx_in[p].data = d;
    n = 0;
    do begin
      ok = rx_ready[p];
      tick();
      n++;
    end while (!ok && n < 100);
    chk({15'h0000, ok}, 16'h0001);
  endtask : send_byte

  task term(input int p);
    rx_in[p].valid = 1'b0;
    rx_in[p].term = 1'b1;
    tick();
    rx_in[p].term = 1'b0;
    tick();
    tick();
  endtask : term

  // host hands the files back and waits for word 0
  task run_blk();
    int n;
    int b;
    b = host.blk_cnt;
    host_word0 = {9'h000, seq};
    n = 0;
    while (host.blk_cnt == b && n < 3000) begin
      tick();
      n++;
    end
    // a block that never finishes counts as a mismatch
    chk(16'(n >= 3000), 16'h0000);
    chk(host.mem[0], {9'h000, seq + 7'h01});
    chk(host.mem[405], 16'h5a5a);
    seq = seq + 7'h01;
  endtask : run_blk

  task t_idle();
    tx_acc[0] = 10'h190;
    tx_acc[1] = 10'h000;
    run_blk();
    chk(host.mem[1], 16'h0000);
    chk(host.mem[3], 16'h0000);
    chk(host.mem[2], 16'h0190);
    chk(host.mem[203], 16'h0000);
    chk(host.mem[204], 16'h0000);
    $display("done idle");
  endtask : t_idle

  task t_short();
    send_byte(0, 8'ha1);
    send_byte(0, 8'hb2);
    send_byte(0, 8'hc3);
    term(0);
    tx_acc[0] = 10'h005;
    tx_acc[1] = 10'h07f;
    run_blk();
    chk(host.mem[1], 16'h0003);
    chk(host.mem[3], 16'hb2a1);
    chk(host.mem[4], 16'h00c3);
    chk(host.mem[2], 16'h0005);
    chk(host.mem[204], 16'h007f);
    chk(host.mem[203], 16'h0000);
    $display("done short");
  endtask : t_short

  task t_hold();
    for (int i = 0; i < 402; i++) send_byte(1, i[7:0]);
    rx_in[1].valid = 1'b0;
    tick();
    run_blk();
    chk(host.mem[203], 16'h0000);
    chk(host.mem[205], 16'h0192);
    term(1);
    slow = 1'b1;
    run_blk();
    chk(host.mem[203], LEN_CONT);
    chk(host.mem[205], 16'h0100);
    chk(host.mem[404], 16'h8f8e);
    slow = 1'b0;
    run_blk();
    chk(host.mem[203], 16'h0002);
    chk(host.mem[205], 16'h9190);
    chk(host.mem[1], 16'h0000);
    $display("done hold");
  endtask : t_hold

  task t_full();
    int n;
    logic [7:0] b;
    rx_in[0].valid = 1'b1;
    rx_in[0].data = 8'h00;
    n = 0;
    while (rx_ready[0] && n < 5000) begin
      tick();
      n++;
      rx_in[0].data = n[7:0];
    end
    // one byte offered into a full buffer must raise the overflow flag
    tick();
    rx_in[0].valid = 1'b0;
    chk(n[15:0], 16'h1000);
    chk({15'h0000, rx_ready[0]}, 16'h0000);
    term(0);
    for (int k = 0; k < 11; k++) begin
      b = 8'(400 * k);
      run_blk();
      chk(host.mem[1], (k < 10) ? LEN_CONT : 16'h0060);
      chk(host.mem[3], {b + 8'h01, b});
    end
    run_blk();
    chk(host.mem[1], 16'h0000);
    chk(host.mem[5], 16'h0001);
    run_blk();
    chk(host.mem[5], 16'h0000);
    $display("done full");
  endtask : t_full

  // enough empty blocks to pass 127 and come back round
  task t_wrap();
    for (int i = 0; i < 130; i++) run_blk();
    $display("done wrap");
  endtask : t_wrap

  initial begin
    repeat (20) tick();
    srst = 1'b0;
    t_idle();
    t_short();
    t_hold();
    t_full();
    t_wrap();
    end_of_test();
  end

  initial begin
    #450us;
    error_cnt++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : tb_rbs_segmenter
